// ==== scz_regs.svh ====
// Contract
// RULE1: Word is 28 data bits plus 4 address
// RULE2: Sample data on shift rising edge, MSB first
// RULE3: Latch rise copies data to addressed register
// RULE4: Host writes words 0-8, 11, 13-15
// RULE5: Word fifteen write starts calibration unless zero-delay
// RULE6: Host begins with reset bit set
// RULE7: Reset write ignores other word zero bits
// RULE8: Later word zero writes clear reset bit
// RULE9: Ascending order, word fifteen last
// RULE10: Step one: indicate-done, no zero-delay, feedback, enables
// RULE11: Lock source 3/4 shows calibration done
// RULE12: Watch lock pin or wait 2 ms
// RULE13: Step two: zero-delay set, new word fifteen
// RULE14: Gate and sync high, enables set for lock
// RULE15: Feedback channel 5 or external needs 5/6
// RULE16: Zero-delay returns lock pin to digital lock
// RULE17: Gate low in step one, not enables
// RULE18: Host recomputes feedback divider for zero-delay
// RULE19: Gate pin asynchronous; runt and off-frequency possible
// RULE20: Odd bit counts decode the last 32 bits
// RULE21: Reset bit restores all power-on defaults
// RULE22: Lock pin source by indicate-done and zero-delay
// RULE23: Zero-delay blocks calibration, selects feedback mux
// RULE24: Feedback select: 0 ch5, 1 ext, 2 ch6
`ifndef SCZ_REGS_SVH
`define SCZ_REGS_SVH
`define SCZ_WORD_BITS      32
`define SCZ_DATA_BITS      28
`define SCZ_ADDR_BITS      4
`define SCZ_NUM_REGS       16
`define SCZ_ADDR_W0        4'h0
`define SCZ_ADDR_W14       4'he
`define SCZ_ADDR_W15       4'hf
`define SCZ_RESET_POS      27
`define SCZ_DONE_IND_POS   24
`define SCZ_ZDM_POS        23
`define SCZ_FBSEL_HI       22
`define SCZ_FBSEL_LO       21
`define SCZ_EN_POS         12
`define SCZ_GLOBAL_EN_POS  23
`define SCZ_LDSRC_HI       19
`define SCZ_LDSRC_LO       16
`define SCZ_W0_RESET       28'h0000010
`define SCZ_W14_RESET      28'h08000a0
`define SCZ_W15_RESET      28'h0802f80
`define SCZ_WX_RESET       28'h0000010
`define SCZ_CAL_WAIT_NS    2000000
`define SCZ_CLK_NS         50
`define SCZ_CAL_CYCLES     (`SCZ_CAL_WAIT_NS / `SCZ_CLK_NS)
`define SCZ_SCLK_HALF      4
`define SCZ_SETTLE_CYCLES  8
`endif

// ==== scz_pkg.sv ====
package scz_pkg;
    typedef enum logic [1:0] {
        SCZ_FB_CH5  = 2'h0,
        SCZ_FB_EXT  = 2'h1,
        SCZ_FB_CH6  = 2'h2,
        SCZ_FB_RSVD = 2'h3
    } scz_fb_t;
    typedef enum logic [3:0] {
        SCZ_LD_OFF      = 4'h0,
        SCZ_LD_DLD_HI   = 4'h3,
        SCZ_LD_DLD_LO   = 4'h4
    } scz_ldsrc_t;
    typedef enum logic [2:0] {
        SCZ_H_IDLE  = 3'h0,
        SCZ_H_LOAD  = 3'h1,
        SCZ_H_LOW   = 3'h2,
        SCZ_H_HIGH  = 3'h3,
        SCZ_H_LATCH = 3'h4
    } scz_hstate_t;
    typedef enum logic [2:0] {
        SCZ_Q_IDLE   = 3'h0,
        SCZ_Q_SEND   = 3'h1,
        SCZ_Q_WAIT   = 3'h2,
        SCZ_Q_STEP2  = 3'h3,
        SCZ_Q_DONE   = 3'h4
    } scz_seq_t;
endpackage : scz_pkg

// ==== scz_link_if.sv ====
`timescale 1ns/1ps
interface scz_link_if;
    logic serial_shift_clock;
    logic serial_data_in;
    logic serial_latch_enable;
    logic output_gate_pin;
    logic sync_pin;
    logic lock_detect_pin;
    modport dev  (input serial_shift_clock, serial_data_in, serial_latch_enable,
                  output_gate_pin, sync_pin, output lock_detect_pin);
    modport host (output serial_shift_clock, serial_data_in, serial_latch_enable,
                  output_gate_pin, sync_pin, input lock_detect_pin);
endinterface : scz_link_if

// ==== scz_dev.sv ====
`timescale 1ns/1ps
`include "scz_regs.svh"
module scz_dev
    import scz_pkg::*;
(
    // System
    input  wire logic          CLK_SYS,
    input  wire logic          RST,
    // Link
    scz_link_if.dev            LINK,
    // Analog status in
    input  wire logic          PHASE_LOCK,
    input  wire logic          CAL_COMPLETE,
    // Controls out
    output logic               CAL_START,
    output logic [1:0]         FB_SOURCE,
    output logic               NDIV_FROM_FB,
    output logic [7:0]         CHAN_ENABLE,
    output logic [7:0]         CHAN_ACTIVE,
    output logic [27:0]        REG_DATA [0:15]
);
    logic [2:0]  sclk_s, sdat_s, le_s, goe_s;
    logic [1:0]  lk_s, cal_s;
    logic [31:0] shift_reg;
    logic [27:0] regs_reg [0:15];
    logic        cal_pulse_reg;

    ////////////////////////////////////////////////////////////
    // Two-stage sync plus one history stage for edges
    always_ff @(posedge CLK_SYS) begin
        sclk_s <= {sclk_s[1:0], LINK.serial_shift_clock};
        sdat_s <= {sdat_s[1:0], LINK.serial_data_in};
        le_s   <= {le_s[1:0], LINK.serial_latch_enable};
        goe_s  <= {goe_s[1:0], LINK.output_gate_pin};
        lk_s   <= {lk_s[0], PHASE_LOCK};
        cal_s  <= {cal_s[0], CAL_COMPLETE};
    end

    wire        sclk_rise = sclk_s[1] & ~sclk_s[2];
    wire        le_rise   = le_s[1] & ~le_s[2];
    wire [3:0]  addr      = shift_reg[3:0];                       // see RULE1
    wire [27:0] data      = shift_reg[31:4];
    wire        w0_reset  = le_rise && addr == `SCZ_ADDR_W0 && data[`SCZ_RESET_POS];
    wire        zdm       = regs_reg[0][`SCZ_ZDM_POS];
    wire        done_ind  = regs_reg[0][`SCZ_DONE_IND_POS];
    wire [3:0]  ld_src    = regs_reg[14][`SCZ_LDSRC_HI:`SCZ_LDSRC_LO];
    wire        glob_en   = regs_reg[14][`SCZ_GLOBAL_EN_POS];
    // Calibration indication only outside zero-delay mode
    wire        show_cal  = done_ind & ~zdm;                       // see RULE22 see RULE16
    wire        ld_state  = show_cal ? cal_s[1] : lk_s[1];         // see RULE11
    wire        ld_value  = (ld_src == SCZ_LD_DLD_HI) ? ld_state :
                            (ld_src == SCZ_LD_DLD_LO) ? ~ld_state : 1'b0;

    ////////////////////////////////////////////////////////////
    // Shifter keeps only the latest 32 bits
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            shift_reg <= 32'h0;
        end else if (sclk_rise && !le_s[1]) begin
            shift_reg <= {shift_reg[30:0], sdat_s[1]};             // see RULE2 see RULE20
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST || w0_reset) begin
            for (int i = 0; i < 16; i++) begin
                regs_reg[i] <= (i == 14) ? `SCZ_W14_RESET :
                               (i == 15) ? `SCZ_W15_RESET : `SCZ_WX_RESET;  // see RULE21 see RULE7
            end
        end else if (le_rise) begin
            regs_reg[addr] <= data;                               // see RULE3
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            cal_pulse_reg <= 1'b0;
        end else begin
            cal_pulse_reg <= le_rise && addr == `SCZ_ADDR_W15 && !zdm;  // see RULE5 see RULE23
        end
    end

    ////////////////////////////////////////////////////////////
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            REG_DATA[i] = regs_reg[i];
        end
        for (int i = 0; i < 8; i++) begin
            CHAN_ENABLE[i] = regs_reg[i][`SCZ_EN_POS];
        end
    end
    // Gate sampled without clock in silicon: runts possible on rise
    assign CHAN_ACTIVE  = CHAN_ENABLE & {8{glob_en & goe_s[1]}};   // see RULE19
    assign CAL_START    = cal_pulse_reg;
    assign FB_SOURCE    = regs_reg[0][`SCZ_FBSEL_HI:`SCZ_FBSEL_LO];  // see RULE24
    assign NDIV_FROM_FB = zdm;                                     // see RULE23
    assign LINK.lock_detect_pin = ld_value;
endmodule : scz_dev

// ==== scz_host.sv ====
`timescale 1ns/1ps
`include "scz_regs.svh"
module scz_host
    import scz_pkg::*;
#(
    parameter int CAL_CYCLES = `SCZ_CAL_CYCLES
)(
    // System
    input  wire logic          CLK_SYS,
    input  wire logic          RST,
    // Link
    scz_link_if.host           LINK,
    // User
    input  wire logic          START,
    input  wire logic          USE_LD,
    input  wire logic [1:0]    FB_SEL,
    input  wire logic [7:0]    USED_CHANS,
    input  wire logic [27:0]   CFG [0:15],
    input  wire logic [27:0]   W15_STEP2,
    output logic               BUSY,
    output logic               LOCKED
);
    scz_hstate_t hst_reg;
    scz_seq_t    seq_reg;
    logic [31:0] word_reg;
    logic [5:0]  bit_reg;
    logic [2:0]  div_reg;
    logic [4:0]  idx_reg;
    logic [31:0] wait_reg;
    logic [3:0]  settle_reg;
    logic        sclk_reg;
    logic        sdo_reg;
    logic        le_reg;
    logic        goe_reg;
    logic        step2_reg;
    logic        locked_reg;
    logic [1:0]  ld_s;

    always_ff @(posedge CLK_SYS) begin
        ld_s <= {ld_s[0], LINK.lock_detect_pin};
    end

    ////////////////////////////////////////////////////////////
    // Reserved feedback code is never sent; fall back to channel six
    wire [1:0]  fb_use  = (FB_SEL == SCZ_FB_RSVD) ? SCZ_FB_CH6 : FB_SEL;   // see RULE24
    // Channel 6 always, channel 5 too for ch5 or external feedback
    wire [7:0]  en_mask = USED_CHANS | 8'h40 | ((fb_use != SCZ_FB_CH6) ? 8'h20 : 8'h00);  // see RULE15
    // Sequence: 0 reset, 1..16 words, always skipping words 9,10,12
    wire [3:0]  waddr  = (idx_reg == 5'h0) ? 4'h0 : 4'(idx_reg - 5'h1);
    wire        skip   = idx_reg == 5'ha || idx_reg == 5'hb || idx_reg == 5'hd;  // see RULE4
    wire [27:0] base0  = CFG[0];
    wire [27:0] w0_s1  = {1'b0, base0[26:25], 1'b1, 1'b0, fb_use, base0[20:13], en_mask[0],
                          base0[11:0]};                                   // see RULE10 see RULE8
    wire [27:0] w0_s2  = w0_s1 | 28'(1 << `SCZ_ZDM_POS);                  // see RULE13
    wire [27:0] reset_word = 28'(1 << `SCZ_RESET_POS);                    // see RULE6
    wire [27:0] chan_word  = CFG[waddr] | ({27'h0, en_mask[waddr[2:0]]} << `SCZ_EN_POS);
    wire [27:0] w14_word   = CFG[14] | 28'(1 << `SCZ_GLOBAL_EN_POS);      // see RULE14
    wire [27:0] wdata  = (idx_reg == 5'h0) ? reset_word :
                         (step2_reg && waddr == `SCZ_ADDR_W0) ? w0_s2 :
                         (step2_reg) ? W15_STEP2 :                        // see RULE18
                         (waddr == `SCZ_ADDR_W0) ? w0_s1 :
                         (waddr < 4'h8) ? chan_word :
                         (waddr == `SCZ_ADDR_W14) ? w14_word :
                         CFG[waddr];
    // Step two sends word zero, then word fifteen
    wire [3:0]  step2_addr = (idx_reg == 5'h1) ? `SCZ_ADDR_W0 : `SCZ_ADDR_W15;
    wire [3:0]  word_addr  = step2_reg ? step2_addr : waddr;
    wire        word_go = (seq_reg == SCZ_Q_SEND || seq_reg == SCZ_Q_STEP2) && hst_reg == SCZ_H_IDLE;
    wire        tick    = div_reg == 3'(`SCZ_SCLK_HALF - 1);

    ////////////////////////////////////////////////////////////
    // Lock pin meaning follows the source written to word fourteen;
    // any other source gives no calibration flag, so fall back to timing
    wire [3:0]  ld_src    = CFG[14][`SCZ_LDSRC_HI:`SCZ_LDSRC_LO];
    wire        ld_sel    = ld_src == SCZ_LD_DLD_HI || ld_src == SCZ_LD_DLD_LO;
    wire        ld_active = (ld_src == SCZ_LD_DLD_LO) ? ~ld_s[1] : ld_s[1];   // see RULE11
    wire        cal_timed = wait_reg >= 32'(CAL_CYCLES);
    wire        cal_ok    = (USE_LD && ld_sel) ? ld_active : cal_timed;       // see RULE12
    wire        settled   = settle_reg == 4'(`SCZ_SETTLE_CYCLES);

    ////////////////////////////////////////////////////////////
    // Bit shifter: data set on low phase, sampled on rise
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            hst_reg  <= SCZ_H_IDLE;
            div_reg  <= 3'h0;
            sclk_reg <= 1'b0;
            sdo_reg  <= 1'b0;
            le_reg   <= 1'b1;
            bit_reg  <= 6'h0;
            word_reg <= 32'h0;
        end else begin
            div_reg <= (hst_reg == SCZ_H_IDLE || tick) ? 3'h0 : div_reg + 3'h1;
            unique case (hst_reg)
                SCZ_H_IDLE: if (word_go && !skip) begin
                    word_reg <= {wdata, word_addr};                   // see RULE1
                    le_reg   <= 1'b0;
                    bit_reg  <= 6'h0;
                    hst_reg  <= SCZ_H_LOAD;
                end
                SCZ_H_LOAD: begin
                    sdo_reg  <= word_reg[31];                          // see RULE2
                    word_reg <= {word_reg[30:0], 1'b0};
                    hst_reg  <= SCZ_H_LOW;
                end
                SCZ_H_LOW: if (tick) begin
                    sclk_reg <= 1'b1;
                    bit_reg  <= bit_reg + 6'h1;
                    hst_reg  <= SCZ_H_HIGH;
                end
                SCZ_H_HIGH: if (tick) begin
                    sclk_reg <= 1'b0;
                    hst_reg  <= (bit_reg == 6'h20) ? SCZ_H_LATCH : SCZ_H_LOAD;
                end
                SCZ_H_LATCH: if (tick) begin
                    le_reg  <= 1'b1;                                  // see RULE3
                    hst_reg <= SCZ_H_IDLE;
                end
                default: hst_reg <= SCZ_H_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////
    // Word sequencer, ascending order, word fifteen last
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            seq_reg    <= SCZ_Q_IDLE;
            idx_reg    <= 5'h0;
            step2_reg  <= 1'b0;
            goe_reg    <= 1'b0;
            wait_reg   <= 32'h0;
            settle_reg <= 4'h0;
            locked_reg <= 1'b0;
        end else begin
            unique case (seq_reg)
                SCZ_Q_IDLE: if (START) begin
                    idx_reg    <= 5'h0;
                    step2_reg  <= 1'b0;
                    goe_reg    <= 1'b0;                               // see RULE17
                    locked_reg <= 1'b0;
                    seq_reg    <= SCZ_Q_SEND;
                end
                SCZ_Q_SEND: if (word_go) begin
                    idx_reg <= idx_reg + 5'h1;                        // see RULE9
                    if (idx_reg == 5'h10) begin
                        wait_reg <= 32'h0;
                        seq_reg  <= SCZ_Q_WAIT;
                    end
                end
                SCZ_Q_WAIT: if (hst_reg == SCZ_H_IDLE) begin
                    // Saturate so a long pin wait cannot wrap the timer
                    if (!cal_timed) begin
                        wait_reg <= wait_reg + 32'h1;
                    end
                    if (cal_ok) begin
                        goe_reg   <= 1'b1;                            // see RULE14
                        step2_reg <= 1'b1;
                        idx_reg   <= 5'h1;
                        seq_reg   <= SCZ_Q_STEP2;
                    end
                end
                SCZ_Q_STEP2: if (word_go) begin
                    idx_reg <= idx_reg + 5'h1;
                    if (idx_reg == 5'h2) begin
                        settle_reg <= 4'h0;
                        seq_reg    <= SCZ_Q_DONE;
                    end
                end
                SCZ_Q_DONE: if (hst_reg == SCZ_H_IDLE) begin
                    // Device commits a few cycles after the latch rises
                    if (!settled) begin
                        settle_reg <= settle_reg + 4'h1;
                    end else begin
                        locked_reg <= ld_active;                      // see RULE16
                    end
                end
                default: seq_reg <= SCZ_Q_IDLE;
            endcase
        end
    end

    assign LINK.serial_shift_clock  = sclk_reg;
    assign LINK.serial_data_in      = sdo_reg;
    assign LINK.serial_latch_enable = le_reg;
    assign LINK.output_gate_pin     = goe_reg;
    assign LINK.sync_pin            = 1'b1;                           // see RULE14
    // Busy until the last word is latched and the device has had time to take it
    assign BUSY   = (seq_reg != SCZ_Q_IDLE && seq_reg != SCZ_Q_DONE) ||
                    hst_reg != SCZ_H_IDLE || (seq_reg == SCZ_Q_DONE && !settled);
    assign LOCKED = locked_reg;
endmodule : scz_host

// ==== scz_link_asserts.sv ====
`timescale 1ns/1ps
`include "scz_regs.svh"
module scz_link_asserts (
    // System
    input wire logic CLK_SYS,
    input wire logic RST,
    // Link
    input wire logic serial_shift_clock,
    input wire logic serial_data_in,
    input wire logic serial_latch_enable,
    input wire logic output_gate_pin,
    input wire logic sync_pin,
    input wire logic lock_detect_pin
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    ////////////////////////////////////////////////////////////////
    logic        le_q;
    logic        sck_q;
    logic [31:0] sr_reg;
    logic [6:0]  bits_reg;
    logic [3:0]  last_addr_reg;
    logic        first_reg;
    logic        w15_seen_reg;
    wire         le_rise  = serial_latch_enable & ~le_q;
    wire         sck_rise = serial_shift_clock & ~sck_q;
    wire  [3:0]  addr     = sr_reg[3:0];
    // Latch reset high so release of reset is no frame end
    always_ff @(posedge CLK_SYS) begin
        le_q  <= RST ? 1'b1 : serial_latch_enable;
        sck_q <= RST ? 1'b0 : serial_shift_clock;
    end
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            sr_reg        <= 32'h0;
            bits_reg      <= 7'h0;
            last_addr_reg <= 4'h0;
            first_reg     <= 1'b1;
            w15_seen_reg  <= 1'b0;
        end else if (le_rise) begin
            bits_reg      <= 7'h0;
            last_addr_reg <= addr;
            first_reg     <= 1'b0;
            w15_seen_reg  <= w15_seen_reg | (addr == 4'hf);
        end else if (sck_rise) begin
            sr_reg   <= {sr_reg[30:0], serial_data_in};
            bits_reg <= bits_reg + 7'h1;
        end
    end
    ////////////////////////////////////////////////////////////////
    sequence s_high_phase;
        serial_shift_clock [*4] ##1 !serial_shift_clock;
    endsequence
    property p_idle_clk; serial_latch_enable |-> !serial_shift_clock; endproperty
    property p_bits32; le_rise |-> bits_reg == 7'h20; endproperty
    property p_high4; $rose(serial_shift_clock) |-> s_high_phase; endproperty
    property p_data_hold;
        serial_shift_clock && $past(serial_shift_clock) |-> $stable(serial_data_in);
    endproperty
    property p_sync_high; sync_pin; endproperty
    property p_first_reset; le_rise && first_reg |-> addr == 4'h0 && sr_reg[31]; endproperty
    property p_later_clear; le_rise && !first_reg && addr == 4'h0 |-> !sr_reg[31]; endproperty
    property p_ascend;
        le_rise && !first_reg |-> addr > last_addr_reg || last_addr_reg == 4'hf ||
                                  (addr == 4'h0 && last_addr_reg == 4'h0);
    endproperty
    property p_gate_late; $rose(output_gate_pin) |-> w15_seen_reg; endproperty
    a_idle_clk: assert property (p_idle_clk) else $error("shift clock moved while latched");
    a_bits32: assert property (p_bits32) else $error("frame length not 32");
    a_high4: assert property (p_high4) else $error("shift clock high phase wrong");
    a_data_hold: assert property (p_data_hold) else $error("data moved while clock high");
    a_sync_high: assert property (p_sync_high) else $error("sync pin low");
    a_first_reset: assert property (p_first_reset) else $error("first word not a reset word");
    a_later_clear: assert property (p_later_clear) else $error("later word zero has reset bit");
    a_ascend: assert property (p_ascend) else $error("address order broken");
    a_gate_late: assert property (p_gate_late) else $error("gate raised before calibration");
endmodule : scz_link_asserts

// ==== scz_tb_top.sv ====
`timescale 1ns/1ps
`include "scz_regs.svh"
module scz_tb_top;
    import scz_pkg::*;
    logic        clk_sys, rst, start, use_ld, phase_lock, cal_complete;
    logic        busy, locked, cal_start, ndiv_from_fb;
    logic [1:0]  fb_sel, fb_source;
    logic [7:0]  used_chans, chan_enable, chan_active;
    logic [27:0] w15_step2;
    logic [27:0] cfg [0:15];
    logic [27:0] reg_data [0:15];
    int          failures, compares, cal_cnt;
    scz_link_if link ();
    scz_host #(.CAL_CYCLES(50)) u_scz_host (.CLK_SYS(clk_sys), .RST(rst), .LINK(link), .START(start),
        .USE_LD(use_ld), .FB_SEL(fb_sel), .USED_CHANS(used_chans), .CFG(cfg), .W15_STEP2(w15_step2),
        .BUSY(busy), .LOCKED(locked));
    scz_dev u_scz_dev (.CLK_SYS(clk_sys), .RST(rst), .LINK(link), .PHASE_LOCK(phase_lock),
        .CAL_COMPLETE(cal_complete), .CAL_START(cal_start), .FB_SOURCE(fb_source),
        .NDIV_FROM_FB(ndiv_from_fb), .CHAN_ENABLE(chan_enable), .CHAN_ACTIVE(chan_active), .REG_DATA(reg_data));
    scz_link_asserts u_scz_link_asserts (.CLK_SYS(clk_sys), .RST(rst),
        .serial_shift_clock(link.serial_shift_clock), .serial_data_in(link.serial_data_in),
        .serial_latch_enable(link.serial_latch_enable), .output_gate_pin(link.output_gate_pin),
        .sync_pin(link.sync_pin), .lock_detect_pin(link.lock_detect_pin));
    ////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) if (cal_start === 1'b1) cal_cnt <= cal_cnt + 1;
    task summarize;
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : summarize
    task chk(string what, logic [27:0] exp, logic [27:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    function automatic logic [7:0] exp_en();
        for (int i = 0; i < 8; i++) exp_en[i] = cfg[i][`SCZ_EN_POS];
    endfunction : exp_en
    ////////////////////////////////////////////////////////////////
    // One full two-step bring-up from a fresh reset
    task run(logic ld, logic [3:0] src);
        int          c0;
        int          n;
        logic [27:0] e0;
        rst = 1'b1;
        repeat (16) @(negedge clk_sys);
        rst = 1'b0;
        fb_sel = 2'($urandom_range(2, 0));
        use_ld = ld;
        cal_complete = 1'b0;
        phase_lock = 1'b1;
        w15_step2 = 28'($urandom);
        for (int a = 0; a < 16; a++) cfg[a] = 28'($urandom);
        cfg[0][`SCZ_RESET_POS] = 1'b0;
        cfg[0][`SCZ_DONE_IND_POS] = 1'b1;
        cfg[0][`SCZ_ZDM_POS] = 1'b0;
        cfg[0][`SCZ_FBSEL_HI:`SCZ_FBSEL_LO] = fb_sel;
        cfg[6][`SCZ_EN_POS] = 1'b1;
        if (fb_sel != SCZ_FB_CH6) cfg[5][`SCZ_EN_POS] = 1'b1;
        cfg[14][`SCZ_GLOBAL_EN_POS] = 1'b1;
        cfg[14][`SCZ_LDSRC_HI:`SCZ_LDSRC_LO] = src;
        used_chans = exp_en();
        c0 = cal_cnt;
        start = 1'b1;
        @(negedge clk_sys);
        start = 1'b0;
        for (n = 0; n < 20000 && cal_cnt == c0; n++) @(negedge clk_sys);
        // Phase lock held high: pin must still show calibration pending
        repeat (20) @(negedge clk_sys);
        chk("cal start pulses", 28'h1, 28'(cal_cnt - c0));
        chk("lock pin during cal", 28'(src == 4'h4), 28'(link.lock_detect_pin));
        chk("gate during cal", 28'h0, 28'(link.output_gate_pin));
        cal_complete = 1'b1;
        for (n = 0; n < 20000 && busy !== 1'b0; n++) @(negedge clk_sys);
        repeat (4) @(negedge clk_sys);
        chk("locked", 28'h1, 28'(locked));
        chk("cal start after step two", 28'h1, 28'(cal_cnt - c0));
        for (int a = 1; a < 15; a++)
            if (a != 9 && a != 10 && a != 12) chk($sformatf("word %0d", a), cfg[a], reg_data[a]);
        chk("word 9 default", `SCZ_WX_RESET, reg_data[9]);
        chk("word 12 default", `SCZ_WX_RESET, reg_data[12]);
        e0 = cfg[0];
        e0[`SCZ_ZDM_POS] = 1'b1;
        chk("word 0", e0, reg_data[0]);
        chk("word 15", w15_step2, reg_data[15]);
        chk("ndiv from fb", 28'h1, 28'(ndiv_from_fb));
        chk("fb source", 28'(fb_sel), 28'(fb_source));
        chk("chan enable", 28'(exp_en()), 28'(chan_enable));
        chk("chan active", 28'(exp_en()), 28'(chan_active));
        phase_lock = 1'b0;
        repeat (8) @(negedge clk_sys);
        chk("lock pin unlocked", 28'(src == 4'h4), 28'(link.lock_detect_pin));
        phase_lock = 1'b1;
        repeat (8) @(negedge clk_sys);
        chk("lock pin locked", 28'(src == 4'h3), 28'(link.lock_detect_pin));
    endtask : run
    ////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        start = 1'b0;
        use_ld = 1'b0;
        fb_sel = 2'h0;
        used_chans = 8'h00;
        phase_lock = 1'b0;
        cal_complete = 1'b0;
        w15_step2 = 28'h0;
        cal_cnt = 0;
        for (int a = 0; a < 16; a++) cfg[a] = 28'h0;
        void'($urandom(64));
        @(negedge clk_sys);
        run(1'b1, 4'h3);
        run(1'b0, 4'h4);
        run(1'b1, 4'h4);
        summarize();
    end
    // Three bring-ups take about 13000 cycles
    initial begin
        repeat (60000) @(posedge clk_sys);
        failures++;
        $display("CHECK FAILED watchdog expected done seen hang");
        summarize();
    end
endmodule : scz_tb_top
